/* hw/scs_clock_ctrl.sv */
// Clock source selection, reset sequencing and domain clock gating
//
// Functional notes
// RULE1 - Four-bit source option picks crystal, RC, or external clock; 0001 reserved.
// RULE2 - Option bits read one unprogrammed, zero programmed; decoded that way.
// RULE3 - Default options: calibrated RC, start-up 10, divide by eight on.
// RULE4 - Internal reset stays on for a time-out after other resets release.
// RULE5 - Time-out counts watchdog cycles: 0, 4096 or 8192, by options.
// RULE6 - Selected oscillator cycles are counted before reset finally releases.
// RULE7 - Start-up count depends on source: 6 external up to 32K.
// RULE8 - From reset: time-out first, then oscillator start-up, then run.
// RULE9 - Wake from power-save or power-down applies start-up count only.
// RULE10 - Each domain clock stops independently according to sleep mode.
// RULE11 - Some external interrupts are seen while peripheral clock stops.
// RULE12 - Two-wire address and serial start events still seen asleep.
// RULE13 - Program-memory clock gates together with the core clock.
// RULE14 - Async timer clock runs from its own oscillator during sleep; the code stops it in power-down and standby.
// RULE15 - Converter clock keeps running while core and peripheral stop.
// RULE16 - Software picks time-out above supply rise unless brown-out used.
// RULE17 - Programmed divide option divides the source clock by eight.
// RULE18 - Options are sampled while reset is held, static afterwards.
module scs_clock_ctrl import scs_pkg::*; #(
	parameter int TOUT_8K  = DEF_TOUT_8K,
	parameter int START_XT = DEF_START_XT,
	parameter int START_LF = DEF_START_LF
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire logic        OSC_LP_XTAL,
	input  wire logic        OSC_FS_XTAL,
	input  wire logic        OSC_LF_XTAL,
	input  wire logic        OSC_RC128K,
	input  wire logic        OSC_RC8M,
	input  wire logic        OSC_EXT,
	input  wire logic        OSC_WDT,
	input  wire logic        OSC_ASY,
	input  wire logic        RESET_SRC,
	input  wire logic        EXT_INT,
	input  wire logic        TWI_ADDR_MATCH,
	input  wire logic        USI_START,
	input  wire logic [3:0]  CLOCK_SOURCE_SELECT_OPTION,
	input  wire logic [1:0]  STARTUP_TIME_OPTION,
	input  wire logic        DIVIDE_BY_EIGHT_OPTION,
	input  wire logic [3:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic [31:0]      AVS_READDATA,
	output logic [1:0]       AVS_RESPONSE,
	output logic             AVS_WAITREQUEST,
	output logic             CPU_CLK_EN,
	output logic             FLASH_CLK_EN,
	output logic             IO_CLK_EN,
	output logic             ADC_CLK_EN,
	output logic             ASY_CLK_EN,
	output logic             INT_RST,
	output logic             SLEEPING
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		scs_state_t  st;
		logic [3:0]  src;
		logic [1:0]  startup_time_option;
		logic        div_opt;
		logic [2:0]  pre;
		scs_sleep_t  mode;
		logic [2:0]  wake_en;
		logic        ack;
		logic [31:0] rdata;
		logic [1:0]  resp;
		logic [4:0]  en;
	} scs_top_st_t;

	scs_top_st_t st_r;
	scs_top_st_t st_nxt;

	localparam logic [CW-1:0] T8K = CW'(TOUT_8K);
	localparam logic [CW-1:0] SXT = CW'(START_XT);
	localparam logic [CW-1:0] SLF = CW'(START_LF);

	// ---------------------------------------------------------------
	// Pin synchronisers and phase counter
	// ---------------------------------------------------------------
	scs_sync_if sy ();
	scs_cnt_if  cn ();

	scs_sync u_sync (
		.clk  (CORE_CLK),
		.rst  (RST),
		.pins ({DIVIDE_BY_EIGHT_OPTION, STARTUP_TIME_OPTION,
			CLOCK_SOURCE_SELECT_OPTION, USI_START, TWI_ADDR_MATCH,
			EXT_INT, RESET_SRC, OSC_ASY, OSC_WDT, OSC_EXT, OSC_RC8M,
			OSC_RC128K, OSC_LF_XTAL, OSC_FS_XTAL, OSC_LP_XTAL}),
		.so   (sy.src)
	);

	scs_cnt u_cnt (
		.clk (CORE_CLK),
		.rst (RST),
		.c   (cn.cnt)
	);

	// ---------------------------------------------------------------
	// Option decode
	// ---------------------------------------------------------------
	logic          src_tick;
	logic [CW-1:0] tout_cyc;
	logic [CW-1:0] start_cyc;
	logic          div_on;
	logic          rsvd;
	logic          sys_tick;
	logic          wake;
	logic          req;

	always_comb begin
		rsvd = (st_r.src == SRC_RSVD);
		// Reserved code falls back to the calibrated RC
		if (st_r.src[3]) begin
			src_tick  = sy.rise[P_LP]; // RULE1
			start_cyc = SXT; // RULE7
		end else if (st_r.src[3:1] == SRC_FS) begin
			src_tick  = sy.rise[P_FS];
			start_cyc = SXT;
		end else if (st_r.src[3:1] == SRC_LF) begin
			src_tick  = sy.rise[P_LF];
			start_cyc = SLF; // RULE7
		end else if (st_r.src == SRC_R128) begin
			src_tick  = sy.rise[P_RC128];
			start_cyc = START_6;
		end else if (st_r.src == SRC_EXT) begin
			src_tick  = sy.rise[P_EXT];
			start_cyc = START_6; // RULE7
		end else begin
			src_tick  = sy.rise[P_RC8M];
			start_cyc = START_6;
		end
		// Zero delay only sensible with brown-out detection
		case (st_r.startup_time_option) // RULE5 RULE16
			SUT_NONE: tout_cyc = TOUT_0;
			SUT_4K:   tout_cyc = TOUT_4K;
			default:  tout_cyc = T8K;
		endcase
		div_on   = (st_r.div_opt == 1'b0); // RULE2 RULE17
		sys_tick = src_tick && (!div_on || st_r.pre == PRE_LAST); // RULE17
		// Wake events arrive synchronised on the free-running clock,
		// independent of any gated domain
		wake = |(st_r.wake_en & {sy.lvl[P_USI], sy.lvl[P_TWI],
			sy.lvl[P_EXTI]}); // RULE11 RULE12
		req  = AVS_READ || AVS_WRITE;
	end

	// ---------------------------------------------------------------
	// Sequencer, gating and register file
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		if (src_tick)
			st_nxt.pre = st_r.pre + 3'h1;

		case (st_r.st)
			ST_LATCH: begin
				st_nxt.st = ST_HOLD;
			end
			ST_HOLD: begin
				// Options track the pins only here
				st_nxt.src     = sy.lvl[P_SRC+:4]; // RULE18
				st_nxt.startup_time_option     = sy.lvl[P_SUT+:2];
				st_nxt.div_opt = sy.lvl[P_DIV];
				if (!sy.lvl[P_RSRC])
					st_nxt.st = ST_TOUT; // RULE4 RULE8
			end
			ST_TOUT: begin
				if (cn.done)
					st_nxt.st = ST_START; // RULE8
			end
			ST_START: begin
				if (cn.done)
					st_nxt.st = ST_RUN; // RULE6
			end
			ST_RUN: begin
				if (AVS_WRITE && st_r.ack && AVS_ADDRESS == A_SLEEP
					&& AVS_BYTEENABLE[0] && AVS_WRITEDATA[SLP_GO])
					st_nxt.st = ST_SLEEP;
			end
			ST_SLEEP: begin
				if (wake) begin
					if (st_r.mode == SM_PDOWN || st_r.mode == SM_PSAVE)
						st_nxt.st = ST_START; // RULE9
					else
						st_nxt.st = ST_RUN;
				end
			end
			default: begin
				st_nxt.st = ST_HOLD;
			end
		endcase
		if (sy.lvl[P_RSRC])
			st_nxt.st = ST_HOLD; // RULE4

		// Domain enables, registered for glitch-free outputs
		st_nxt.en = '0;
		if (st_r.st == ST_RUN) begin
			st_nxt.en[0] = sys_tick;
			st_nxt.en[1] = sys_tick; // RULE13
			st_nxt.en[2] = sys_tick;
			st_nxt.en[3] = sys_tick;
		end else if (st_r.st == ST_SLEEP) begin
			case (st_r.mode) // RULE10
				SM_IDLE: begin
					st_nxt.en[2] = sys_tick;
					st_nxt.en[3] = sys_tick;
				end
				SM_ADCNR: begin
					st_nxt.en[3] = sys_tick; // RULE15
				end
				default: begin
					st_nxt.en[3] = 1'b0;
				end
			endcase
		end
		if (st_r.st != ST_LATCH && st_r.st != ST_HOLD
			&& !(st_r.st == ST_SLEEP
			&& (st_r.mode == SM_PDOWN || st_r.mode == SM_STBY)))
			st_nxt.en[4] = sy.rise[P_ASY]; // RULE14

		// Bus slave: one wait cycle, then answer
		st_nxt.ack = req && !st_r.ack;
		if (req && !st_r.ack) begin
			st_nxt.rdata = '0;
			st_nxt.resp  = RESP_OK;
			case (AVS_ADDRESS)
				A_SLEEP:  st_nxt.rdata[SLP_MD+:3] = st_r.mode;
				A_STATUS: st_nxt.rdata = {16'h0000,
					st_r.wake_en, st_r.st, rsvd, st_r.div_opt,
					st_r.startup_time_option, st_r.src, (st_r.st == ST_SLEEP),
					(st_r.st != ST_RUN && st_r.st != ST_SLEEP)};
				A_WAKE:   st_nxt.rdata[2:0] = st_r.wake_en;
				default:  st_nxt.resp = RESP_ERR;
			endcase
		end
		if (AVS_WRITE && st_r.ack && AVS_BYTEENABLE[0]) begin
			if (AVS_ADDRESS == A_SLEEP)
				st_nxt.mode = scs_sleep_t'(AVS_WRITEDATA[SLP_MD+:3]);
			if (AVS_ADDRESS == A_WAKE)
				st_nxt.wake_en = AVS_WRITEDATA[2:0];
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			st_r         <= '0;
			st_r.st      <= ST_LATCH;
			st_r.src     <= DEF_SRC; // RULE3
			st_r.startup_time_option     <= DEF_SUT;
			st_r.div_opt <= DEF_DIV;
			st_r.mode    <= SM_IDLE;
			st_r.wake_en <= WAKE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Counter restarts at every phase change
	assign cn.clr    = (st_nxt.st != st_r.st);
	assign cn.tick   = (st_r.st == ST_TOUT) ? sy.rise[P_WDT] : src_tick;
	assign cn.target = (st_r.st == ST_TOUT) ? tout_cyc : start_cyc;

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign AVS_WAITREQUEST = req && !st_r.ack;
	assign AVS_READDATA    = st_r.rdata;
	assign AVS_RESPONSE    = st_r.resp;
	assign CPU_CLK_EN      = st_r.en[0];
	assign FLASH_CLK_EN    = st_r.en[1];
	assign IO_CLK_EN       = st_r.en[2];
	assign ADC_CLK_EN      = st_r.en[3];
	assign ASY_CLK_EN      = st_r.en[4];
	assign INT_RST         = st_r.st != ST_RUN && st_r.st != ST_SLEEP;
	assign SLEEPING        = st_r.st == ST_SLEEP;
endmodule

/* inc/scs_pkg.sv */
// Shared constants and types of the clock source and start-up block
package scs_pkg;

	// -------------------------------------------------------------
	// Synchronised pin vector layout
	// -------------------------------------------------------------
	localparam int NSYNC   = 19;
	localparam int P_LP    = 0;
	localparam int P_FS    = 1;
	localparam int P_LF    = 2;
	localparam int P_RC128 = 3;
	localparam int P_RC8M  = 4;
	localparam int P_EXT   = 5;
	localparam int P_WDT   = 6;
	localparam int P_ASY   = 7;
	localparam int P_RSRC  = 8;
	localparam int P_EXTI  = 9;
	localparam int P_TWI   = 10;
	localparam int P_USI   = 11;
	localparam int P_SRC   = 12;
	localparam int P_SUT   = 16;
	localparam int P_DIV   = 18;
	// Reset source reads active until real pin samples arrive
	localparam logic [NSYNC-1:0] SYNC_RST = 19'h00100;

	// -------------------------------------------------------------
	// Option encodings and shipped defaults
	// -------------------------------------------------------------
	localparam logic [3:0] SRC_EXT  = 4'h0;
	localparam logic [3:0] SRC_RSVD = 4'h1;
	localparam logic [3:0] SRC_RC8M = 4'h2;
	localparam logic [3:0] SRC_R128 = 4'h3;
	localparam logic [2:0] SRC_LF   = 3'h2;
	localparam logic [2:0] SRC_FS   = 3'h3;
	localparam logic [3:0] DEF_SRC  = 4'h2;
	localparam logic [1:0] DEF_SUT  = 2'h2;
	localparam logic       DEF_DIV  = 1'b0;
	localparam logic [1:0] SUT_NONE = 2'h0;
	localparam logic [1:0] SUT_4K   = 2'h1;
	localparam logic [2:0] PRE_LAST = 3'h7;

	// -------------------------------------------------------------
	// Cycle counts
	// -------------------------------------------------------------
	localparam int CW = 16;
	localparam logic [CW-1:0] TOUT_0   = 16'h0000;
	localparam logic [CW-1:0] TOUT_4K  = 16'h1000;
	localparam logic [CW-1:0] START_6  = 16'h0006;
	localparam int DEF_TOUT_8K  = 8192;
	localparam int DEF_START_XT = 16384;
	localparam int DEF_START_LF = 32768;

	// -------------------------------------------------------------
	// Register map
	// -------------------------------------------------------------
	localparam logic [3:0] A_SLEEP  = 4'h0;
	localparam logic [3:0] A_STATUS = 4'h4;
	localparam logic [3:0] A_WAKE   = 4'h8;
	localparam int SLP_GO  = 0;
	localparam int SLP_MD  = 1;
	localparam logic [2:0] WAKE_RST = 3'h7;
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	typedef enum logic [2:0] {
		SM_IDLE, SM_ADCNR, SM_PDOWN, SM_PSAVE, SM_STBY
	} scs_sleep_t;

	typedef enum logic [2:0] {
		ST_LATCH, ST_HOLD, ST_TOUT, ST_START, ST_RUN, ST_SLEEP
	} scs_state_t;

endpackage

/* inc/scs_if.sv */
// Carriers between the top block and its helper modules
interface scs_sync_if import scs_pkg::*; ();
	logic [NSYNC-1:0] lvl;
	logic [NSYNC-1:0] rise;
	modport src (output lvl, output rise);
	modport dst (input lvl, input rise);
endinterface

interface scs_cnt_if import scs_pkg::*; ();
	logic          clr;
	logic          tick;
	logic [CW-1:0] target;
	logic          done;
	modport ctl (output clr, output tick, output target, input done);
	modport cnt (input clr, input tick, input target, output done);
endinterface

/* hw/scs_sync.sv */
// Two-stage pin synchroniser with rising-edge detect
module scs_sync import scs_pkg::*; (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [NSYNC-1:0] pins,
	scs_sync_if.src               so
);
	typedef struct packed {
		logic [NSYNC-1:0] s1;
		logic [NSYNC-1:0] s2;
		logic [NSYNC-1:0] s3;
	} scs_sync_st_t;

	scs_sync_st_t st_r;
	scs_sync_st_t st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = pins;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
	end

	always_ff @(posedge clk or posedge rst) begin
		// Keeps the sequencer in hold while the stages fill
		if (rst)
			st_r <= {SYNC_RST, SYNC_RST, SYNC_RST};
		else
			st_r <= st_nxt;
	end

	// Edge seen only past the second stage
	assign so.lvl  = st_r.s2;
	assign so.rise = st_r.s2 & ~st_r.s3;
endmodule

/* hw/scs_cnt.sv */
// Tick counter shared by the time-out and start-up phases
module scs_cnt import scs_pkg::*; (
	input  wire logic clk,
	input  wire logic rst,
	scs_cnt_if.cnt    c
);
	typedef struct packed {
		logic [CW-1:0] cnt;
	} scs_cnt_st_t;

	scs_cnt_st_t st_r;
	scs_cnt_st_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (c.clr)
			st_nxt.cnt = '0;
		else if (c.tick && !c.done)
			st_nxt.cnt = st_r.cnt + 16'h0001;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// A zero target finishes at once
	assign c.done = (st_r.cnt >= c.target);
endmodule

/* bench/scs_clock_ctrl_props.sv */
// Port checker of the clock source and start-up block
module scs_props (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic RESET_SRC,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic AVS_WAITREQUEST,
	input wire logic CPU_CLK_EN,
	input wire logic FLASH_CLK_EN,
	input wire logic IO_CLK_EN,
	input wire logic ADC_CLK_EN,
	input wire logic INT_RST,
	input wire logic SLEEPING
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// ----------
	// Assertions
	// ----------
	// Depth 4 leaves room for pulses already in the enable pipeline
	hold_gate_a: assert property (
		INT_RST && $past(INT_RST, 4) |->
		!(CPU_CLK_EN || IO_CLK_EN || ADC_CLK_EN)
	) else $error("Domain enable during internal reset");
	flash_cpu_a: assert property (
		FLASH_CLK_EN == CPU_CLK_EN
	) else $error("Memory clock apart from core clock");
	sleep_cpu_a: assert property (
		SLEEPING && $past(SLEEPING, 4) |-> !CPU_CLK_EN
	) else $error("Core clock runs while asleep");
	sleep_rst_a: assert property (
		SLEEPING |-> !INT_RST
	) else $error("Internal reset while asleep");
	src_hold_a: assert property (
		$rose(RESET_SRC) |-> ##[1:5] INT_RST
	) else $error("Reset source not followed");
	tout_hold_a: assert property (
		$fell(RESET_SRC) |-> INT_RST [*8]
	) else $error("Internal reset released too soon");
	cpu_pulse_a: assert property (
		CPU_CLK_EN |=> !CPU_CLK_EN
	) else $error("Core enable longer than one cycle");
	bus_wait_a: assert property (
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST
	) else $error("Bus answer late");
	// ------
	// Covers
	// ------
	cover property ($fell(INT_RST));
	cover property (SLEEPING && ADC_CLK_EN);
	cover property ($fell(SLEEPING));
endmodule

bind scs_clock_ctrl scs_props u_props (
	.CORE_CLK        (CORE_CLK),
	.RST             (RST),
	.RESET_SRC       (RESET_SRC),
	.AVS_READ        (AVS_READ),
	.AVS_WRITE       (AVS_WRITE),
	.AVS_WAITREQUEST (AVS_WAITREQUEST),
	.CPU_CLK_EN      (CPU_CLK_EN),
	.FLASH_CLK_EN    (FLASH_CLK_EN),
	.IO_CLK_EN       (IO_CLK_EN),
	.ADC_CLK_EN      (ADC_CLK_EN),
	.INT_RST         (INT_RST),
	.SLEEPING        (SLEEPING)
);

/* bench/scs_clock_ctrl_test.sv */
// Self-checking bench of the clock source and start-up block
module scs_clock_ctrl_test import scs_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        rsrc = 1'b1;
	logic [7:0]  osc = 8'h00;
	logic [2:0]  wk = 3'h0;
	logic [3:0]  src = DEF_SRC;
	logic [1:0]  startup_time_option = DEF_SUT;
	logic        div = DEF_DIV;
	logic [3:0]  adr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] rdata;
	logic [1:0]  resp;
	logic        wreq;
	logic [4:0]  en;
	logic        irst;
	logic        slp;
	logic [33:0] q[$];
	logic [33:0] e;
	int          cnt[5] = '{0, 0, 0, 0, 0};
	int          cs[5];
	int          err_total = 0;
	int          checks = 0;
	int          wm[4] = '{1, 0, 2, 0};
	int          ex[4][5] = '{'{0, 0, 4, 4, 4}, '{0, 0, 0, 4, 4},
		'{0, 0, 0, 0, 0}, '{0, 0, 0, 0, 4}};

	scs_clock_ctrl #(.TOUT_8K(20), .START_XT(12), .START_LF(24)) dut (
		.CORE_CLK(clk), .RST(rst), .OSC_LP_XTAL(osc[P_LP]),
		.OSC_FS_XTAL(osc[P_FS]), .OSC_LF_XTAL(osc[P_LF]),
		.OSC_RC128K(osc[P_RC128]), .OSC_RC8M(osc[P_RC8M]),
		.OSC_EXT(osc[P_EXT]), .OSC_WDT(osc[P_WDT]), .OSC_ASY(osc[P_ASY]),
		.RESET_SRC(rsrc), .EXT_INT(wk[0]), .TWI_ADDR_MATCH(wk[1]),
		.USI_START(wk[2]), .CLOCK_SOURCE_SELECT_OPTION(src),
		.STARTUP_TIME_OPTION(startup_time_option), .DIVIDE_BY_EIGHT_OPTION(div),
		.AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
		.AVS_RESPONSE(resp), .AVS_WAITREQUEST(wreq), .CPU_CLK_EN(en[0]),
		.FLASH_CLK_EN(en[1]), .IO_CLK_EN(en[2]), .ADC_CLK_EN(en[3]),
		.ASY_CLK_EN(en[4]), .INT_RST(irst), .SLEEPING(slp));

	// -----
	// Tasks
	// -----
	task automatic summarize();
		$display("Comparisons %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input string n, input logic [33:0] x, g);
		checks++;
		if (g !== x) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask

	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wd <= d;
		rd <= !w;
		wr <= w;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 50) begin
			err_total++;
			summarize();
		end
		@(posedge clk);
	endtask

	task automatic rdq(input logic [3:0] a, input logic [33:0] x);
		q.push_back(x);
		bus(1'b0, a, 32'h0);
	endtask

	// Status word as the options and state should show it
	function automatic logic [33:0] st(input logic r, s, input logic [2:0] m);
		return {18'h0, 3'h7, m, src == SRC_RSVD, div, startup_time_option, src, s, r};
	endfunction

	// Oscillator cycles: four clocks high, four low
	task automatic pul(input int i, input int n);
		repeat (n) begin
			osc[i] <= 1'b1;
			repeat (4) @(posedge clk);
			osc[i] <= 1'b0;
			repeat (4) @(posedge clk);
		end
		repeat (6) @(posedge clk);
	endtask

	task automatic seq(input logic [3:0] s, input logic [1:0] u,
		input logic d, input int i, t, k);
		src <= s;
		startup_time_option <= u;
		div <= d;
		rsrc <= 1'b1;
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat ($urandom_range(3, 9)) @(posedge clk);
		rsrc <= 1'b0;
		if (t > 0) begin
			pul(i, 3);
			pul(P_WDT, t - 1);
			rdq(A_STATUS, st(1, 0, 2));
			pul(P_WDT, 1);
		end
		else
			pul(i, 0);
		rdq(A_STATUS, st(1, 0, 3));
		pul(i, k - 1);
		rdq(A_STATUS, st(1, 0, 3));
		pul(i, 1);
		rdq(A_STATUS, st(0, 0, 4));
		$display("Start-up from source %h done", s);
	endtask

	// -------
	// Monitor
	// -------
	always @(posedge clk) begin
		for (int i = 0; i < 5; i++)
			if (en[i] === 1'b1)
				cnt[i]++;
		if (rd && wreq === 1'b0)
			chk("read", q.pop_front(), {resp, rdata});
	end

	initial begin
		forever #5 clk = ~clk;
	end

	// ----
	// Main
	// ----
	initial begin
		void'($urandom(32'h034B66B5));
		@(posedge clk);
		seq(DEF_SRC, DEF_SUT, DEF_DIV, P_RC8M, 20, 6);
		cs = cnt;
		pul(P_RC8M, 16);
		chk("divided", 34'(2), 34'(cnt[0] - cs[0]));
		bus(1'b1, A_WAKE, ($urandom() & 32'hFFFFFFF8) | 32'h5);
		rdq(A_WAKE, 34'h5);
		rdq(4'hC, {RESP_ERR, 32'h0});
		$display("Divider and register access done");
		seq(4'hF, SUT_4K, 1'b1, P_LP, 4096, 12);
		seq(4'hA, SUT_NONE, 1'b1, P_LP, 0, 12);
		seq(4'h7, SUT_NONE, 1'b1, P_FS, 0, 12);
		seq(4'h6, 2'h3, 1'b1, P_FS, 20, 12);
		seq(4'h5, 2'h2, 1'b1, P_LF, 20, 24);
		seq(4'h4, SUT_NONE, 1'b1, P_LF, 0, 24);
		seq(SRC_R128, SUT_NONE, 1'b1, P_RC128, 0, 6);
		seq(SRC_EXT, 2'h2, 1'b1, P_EXT, 20, 6);
		seq(SRC_RSVD, SUT_NONE, 1'b1, P_RC8M, 0, 6);
		seq(SRC_RC8M, SUT_NONE, 1'b1, P_RC8M, 0, 6);
		for (int m = 0; m < 4; m++) begin
			cs = cnt;
			bus(1'b1, A_SLEEP, {28'h0, 3'(m), 1'b1});
			rdq(A_STATUS, st(0, 1, 5));
			pul(P_RC8M, 4);
			pul(P_ASY, 4);
			for (int i = 0; i < 5; i++)
				chk("domain", 34'(ex[m][i]), 34'(cnt[i] - cs[i]));
			wk[wm[m]] <= 1'b1;
			repeat (8) @(posedge clk);
			wk[wm[m]] <= 1'b0;
			if (m >= 2) begin
				rdq(A_STATUS, st(1, 0, 3));
				pul(P_RC8M, 6);
			end
			rdq(A_STATUS, st(0, 0, 4));
			$display("Sleep mode %0d done", m);
		end
		e = st(0, 0, 4);
		src <= 4'h3;
		repeat (8) @(posedge clk);
		rdq(A_STATUS, e);
		rsrc <= 1'b1;
		repeat (8) @(posedge clk);
		rdq(A_STATUS, st(1, 0, 1));
		rsrc <= 1'b0;
		repeat (20) @(posedge clk);
		$display("Option hold and reset source done");
		summarize();
	end
endmodule
